// File: common/uir_regs.svh
// register offsets, field positions, reset values and trigger levels of the uart register block
// assumes nothing: definitions only
`ifndef UIR_REGS_SVH
`define UIR_REGS_SVH

// ----------------------------------------
// offsets on the three address lines
// ----------------------------------------
`define UIR_OFS_DATA 3'h0
`define UIR_OFS_IEN 3'h1
`define UIR_OFS_ISTAT 3'h2
`define UIR_OFS_LCTL 3'h3
`define UIR_OFS_MCTL 3'h4
`define UIR_OFS_LSTAT 3'h5
`define UIR_OFS_MSTAT 3'h6
`define UIR_OFS_SCRATCH 3'h7

// ----------------------------------------
// field positions and special values
// ----------------------------------------
`define UIR_LCR_DIV_BIT 7
`define UIR_LCR_ENH_VALUE 8'hBF
`define UIR_EFR_UNLOCK_BIT 4
`define UIR_XFR_LSR_MODE_BIT 3
`define UIR_FCR_EN_BIT 0
`define UIR_FCR_RXRST_BIT 1
`define UIR_FCR_TXRST_BIT 2
`define UIR_IER_RX_BIT 0
`define UIR_IER_TX_BIT 1
`define UIR_IER_LS_BIT 2
`define UIR_IER_MS_BIT 3

// ----------------------------------------
// status codes and reset values
// ----------------------------------------
`define UIR_ISR_LINE 6'h06
`define UIR_ISR_RXDATA 6'h04
`define UIR_ISR_TRANSMIT_READY_IRQ 6'h02
`define UIR_ISR_MODEM 6'h00
`define UIR_ISR_NONE 6'h01
`define UIR_RST_REG 8'h00
`define UIR_RST_LCR 8'h03

// ----------------------------------------
// receive trigger levels, fifo of eight
// ----------------------------------------
`define UIR_RX_TRIG_0 4'h1
`define UIR_RX_TRIG_1 4'h2
`define UIR_RX_TRIG_2 4'h4
`define UIR_RX_TRIG_3 4'h7
`define UIR_FIFO_DEPTH 8

`endif

// File: common/uir_pkg.sv
// types shared by the uart register block
// needs nothing from uir_regs.svh: types only, no constants
package uir_pkg;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [2:0] addr;
    logic [7:0] wdata;
  } uir_bus_req_t;

  // received character with its error flags
  typedef struct packed {
    logic brk;
    logic frm;
    logic par;
    logic [7:0] data;
  } uir_rx_char_t;

  typedef struct packed {
    logic [15:0] divisor;
    logic [7:0] line_control_reg;
    logic [7:0] modem_control_reg;
    logic [7:0] enhanced_feature_ctrl;
    logic [7:0] extra_feature_reg;
    logic [7:0] infrared_pulse_width_reg;
    logic [7:0] resume_one;
    logic [7:0] resume_two;
    logic [7:0] pause_one;
    logic [7:0] pause_two;
    logic fifo_en;
    logic [1:0] tx_trig;
  } uir_cfg_t;

  typedef struct packed {
    logic [7:0] line_control_reg;
    logic [7:0] dll;
    logic [7:0] divisor_high;
    logic [7:0] irq_enable_reg;
    logic [7:0] enhanced_feature_ctrl;
    logic [7:0] modem_control_reg;
    logic [7:0] extra_feature_reg;
    logic [7:0] infrared_pulse_width_reg;
    logic [7:0] spr;
    logic [7:0] resume_char_one;
    logic [7:0] resume_char_two;
    logic [7:0] pause_char_one;
    logic [7:0] pause_char_two;
    logic fifo_en;
    logic [1:0] rx_trig;
    logic [1:0] tx_trig;
    logic [7:0] tx_holding_reg;
    logic thr_full;
    logic ovr;
    logic ls_pend;
    logic tx_pend;
    logic hd_fresh;
    logic [3:0] err_cnt;
    logic [7:0] rd_data;
    logic irq;
  } uir_state_t;

endpackage : uir_pkg

// File: src/uir_top.sv
// uart host register block: divisor, enhanced and flow-control registers, interrupt enables and line status
// assumes one clock, a synchronous host bus with one-cycle rd/wr strobes, and outside serial datapaths
`timescale 1ns/100ps
`include "uir_regs.svh"
`default_nettype none

// ----------------------------------------
// receive fifo
// ----------------------------------------
module uir_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic flush,
  input wire logic in_vld,
  output logic in_rdy,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_vld,
  input wire logic out_rdy,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH+1)-1:0] level
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  typedef struct packed {
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [CW-1:0] cnt;
    logic in_rdy;
    logic out_vld;
  } uir_fifo_state_t;

  uir_fifo_state_t st_ff;
  uir_fifo_state_t nxt_st;
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic push;
  logic pop;

  assign push = in_vld && st_ff.in_rdy;
  assign pop = out_rdy && st_ff.out_vld;
  assign in_rdy = st_ff.in_rdy;
  assign out_vld = st_ff.out_vld;
  assign out_data = mem_ff[st_ff.rp];
  assign level = st_ff.cnt;

  always_comb begin
    nxt_st = st_ff;
    if (flush) begin
      nxt_st.wp = '0;
      nxt_st.rp = '0;
      nxt_st.cnt = '0;
    end else begin
      if (push) begin
        nxt_st.wp = (st_ff.wp == PW'(DEPTH - 1)) ? '0 : st_ff.wp + 1'b1;
      end
      if (pop) begin
        nxt_st.rp = (st_ff.rp == PW'(DEPTH - 1)) ? '0 : st_ff.rp + 1'b1;
      end
      nxt_st.cnt = st_ff.cnt + CW'(push) - CW'(pop);
    end
    // flags registered so both handshake outputs come from flops
    nxt_st.in_rdy = nxt_st.cnt != CW'(DEPTH);
    nxt_st.out_vld = nxt_st.cnt != '0;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // storage needs no reset, only written on a push
  always_ff @(posedge clk) begin
    if (push && !flush) begin
      mem_ff[st_ff.wp] <= in_data;
    end
  end
endmodule : uir_fifo

// ----------------------------------------
// register block
// ----------------------------------------
module uir_top import uir_pkg::*; #(
  parameter logic [7:0] REVISION_CODE = 8'h01,
  parameter logic [7:0] DEVICE_CODE = 8'h5A // arbitrary value
) (
  input wire logic clk,
  input wire logic srst,
  input wire uir_bus_req_t bus_req,
  output logic [7:0] bus_rdata,
  output logic irq,
  input wire logic rx_vld,
  output logic rx_rdy,
  input wire uir_rx_char_t rx_char,
  input wire logic rx_overrun,
  output logic tx_vld,
  output logic [7:0] tx_data,
  input wire logic tx_take,
  input wire logic tsr_empty,
  input wire logic [7:0] modem_in,
  output uir_cfg_t cfg
);

  uir_state_t st_ff;
  uir_state_t nxt_st;
  uir_rx_char_t head;
  logic head_vld;
  logic [3:0] level;
  logic rd_data_pop;
  logic rx_push;
  logic enh;
  logic dlab;
  logic unlock;
  logic [7:0] line_status_reg;
  logic [7:0] irq_status_reg;
  logic rx_src;
  logic ms_src;
  logic rx_flush;

  function automatic logic [3:0] trig_level(input logic [1:0] sel);
    case (sel)
      2'h0: trig_level = `UIR_RX_TRIG_0;
      2'h1: trig_level = `UIR_RX_TRIG_1;
      2'h2: trig_level = `UIR_RX_TRIG_2;
      default: trig_level = `UIR_RX_TRIG_3;
    endcase
  endfunction : trig_level

  function automatic logic has_err(input uir_rx_char_t c);
    has_err = c.brk || c.frm || c.par;
  endfunction : has_err

  assign enh = st_ff.line_control_reg == `UIR_LCR_ENH_VALUE;
  assign dlab = st_ff.line_control_reg[`UIR_LCR_DIV_BIT];
  assign unlock = st_ff.enhanced_feature_ctrl[`UIR_EFR_UNLOCK_BIT];
  assign rx_push = rx_vld && rx_rdy;
  assign rd_data_pop = bus_req.rd && !dlab && bus_req.addr == `UIR_OFS_DATA;
  assign rx_flush = bus_req.wr && !dlab && bus_req.addr == `UIR_OFS_ISTAT
    && bus_req.wdata[`UIR_FCR_EN_BIT] && bus_req.wdata[`UIR_FCR_RXRST_BIT];

  uir_fifo #(
    .WIDTH(11),
    .DEPTH(`UIR_FIFO_DEPTH)
  ) u_rx_fifo (
    .clk(clk),
    .srst(srst),
    .flush(rx_flush),
    .in_vld(rx_vld),
    .in_rdy(rx_rdy),
    .in_data(rx_char),
    .out_vld(head_vld),
    .out_rdy(rd_data_pop),
    .out_data(head),
    .level(level)
  );

  // ----------------------------------------
  // status views
  // ----------------------------------------
  always_comb begin
    line_status_reg = 8'h00;
    line_status_reg[0] = head_vld;
    line_status_reg[1] = st_ff.ovr;
    line_status_reg[2] = head_vld && head.par;
    line_status_reg[3] = head_vld && head.frm;
    line_status_reg[4] = head_vld && head.brk;
    line_status_reg[5] = !st_ff.thr_full;
    line_status_reg[6] = !st_ff.thr_full && tsr_empty;
    line_status_reg[7] = st_ff.err_cnt != 4'h0;
  end

  // fifo mode waits for the trigger, plain mode for one character
  assign rx_src = st_ff.fifo_en ? (level >= trig_level(st_ff.rx_trig)) : head_vld;
  assign ms_src = modem_in[3:0] != 4'h0;

  always_comb begin
    irq_status_reg = 8'h00;
    irq_status_reg[7:6] = {2{st_ff.fifo_en}};
    // sources masked individually by the enable register
    if (st_ff.irq_enable_reg[`UIR_IER_LS_BIT] && st_ff.ls_pend) begin
      irq_status_reg[5:0] = `UIR_ISR_LINE;
    end else if (st_ff.irq_enable_reg[`UIR_IER_RX_BIT] && rx_src) begin
      irq_status_reg[5:0] = `UIR_ISR_RXDATA;
    end else if (st_ff.irq_enable_reg[`UIR_IER_TX_BIT] && st_ff.tx_pend) begin
      irq_status_reg[5:0] = `UIR_ISR_TRANSMIT_READY_IRQ;
    end else if (st_ff.irq_enable_reg[`UIR_IER_MS_BIT] && ms_src) begin
      irq_status_reg[5:0] = `UIR_ISR_MODEM;
    end else begin
      irq_status_reg[5:0] = `UIR_ISR_NONE;
    end
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rd_data = 8'h00;
    // host side: reads
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        `UIR_OFS_DATA: begin
          if (dlab && !enh) begin
            // zero divisor exposes the identity bytes
            nxt_st.rd_data = ({st_ff.divisor_high, st_ff.dll} == 16'h0000) ? REVISION_CODE : st_ff.dll;
          end else if (!dlab) begin
            nxt_st.rd_data = head.data;
          end
        end
        `UIR_OFS_IEN: begin
          if (dlab && !enh) begin
            nxt_st.rd_data = ({st_ff.divisor_high, st_ff.dll} == 16'h0000) ? DEVICE_CODE : st_ff.divisor_high;
          end else if (!dlab) begin
            nxt_st.rd_data = st_ff.irq_enable_reg;
          end
        end
        `UIR_OFS_ISTAT: begin
          if (enh) begin
            nxt_st.rd_data = st_ff.enhanced_feature_ctrl;
          end else if (!dlab) begin
            nxt_st.rd_data = irq_status_reg;
            nxt_st.tx_pend = 1'b0;
          end
        end
        `UIR_OFS_LCTL: nxt_st.rd_data = st_ff.line_control_reg;
        `UIR_OFS_MCTL: nxt_st.rd_data = enh ? st_ff.resume_char_one : (dlab ? 8'h00 : st_ff.modem_control_reg);
        `UIR_OFS_LSTAT: begin
          if (enh) begin
            nxt_st.rd_data = st_ff.resume_char_two;
          end else if (!dlab) begin
            nxt_st.rd_data = line_status_reg;
            nxt_st.ls_pend = 1'b0;
            nxt_st.ovr = 1'b0;
          end
        end
        `UIR_OFS_MSTAT: begin
          if (enh) begin
            nxt_st.rd_data = st_ff.pause_char_one;
          end else if (!dlab) begin
            nxt_st.rd_data = unlock ? modem_in : {4'h0, modem_in[3:0]};
          end
        end
        `UIR_OFS_SCRATCH: nxt_st.rd_data = enh ? st_ff.pause_char_two : (dlab ? 8'h00 : st_ff.spr);
      endcase
    end
    // host side: writes
    if (bus_req.wr) begin
      unique case (bus_req.addr)
        `UIR_OFS_DATA: begin
          if (dlab && !enh) begin
            nxt_st.dll = bus_req.wdata;
          end else if (!dlab) begin
            nxt_st.tx_holding_reg = bus_req.wdata;
            nxt_st.thr_full = 1'b1;
            nxt_st.tx_pend = 1'b0;
          end
        end
        `UIR_OFS_IEN: begin
          if (dlab && !enh) begin
            nxt_st.divisor_high = bus_req.wdata;
          end else if (!dlab) begin
            nxt_st.irq_enable_reg[3:0] = bus_req.wdata[3:0];
            if (unlock) begin
              nxt_st.irq_enable_reg[7:4] = bus_req.wdata[7:4];
            end
            // turning the enable on while already empty raises it at once
            if (bus_req.wdata[`UIR_IER_TX_BIT] && !st_ff.irq_enable_reg[`UIR_IER_TX_BIT] && !st_ff.thr_full) begin
              nxt_st.tx_pend = 1'b1;
            end
          end
        end
        `UIR_OFS_ISTAT: begin
          if (enh) begin
            nxt_st.enhanced_feature_ctrl = bus_req.wdata;
          end else if (!dlab) begin
            nxt_st.fifo_en = bus_req.wdata[`UIR_FCR_EN_BIT];
            // other fields only take effect with the enable bit set
            if (bus_req.wdata[`UIR_FCR_EN_BIT]) begin
              nxt_st.rx_trig = bus_req.wdata[7:6];
              if (unlock) begin
                nxt_st.tx_trig = bus_req.wdata[5:4];
              end
              if (bus_req.wdata[`UIR_FCR_TXRST_BIT]) begin
                nxt_st.thr_full = 1'b0;
              end
              if (bus_req.wdata[`UIR_FCR_RXRST_BIT]) begin
                nxt_st.err_cnt = 4'h0;
              end
            end
          end
        end
        `UIR_OFS_LCTL: nxt_st.line_control_reg = bus_req.wdata;
        `UIR_OFS_MCTL: begin
          if (enh) begin
            nxt_st.resume_char_one = bus_req.wdata;
          end else if (!dlab) begin
            nxt_st.modem_control_reg[4:0] = bus_req.wdata[4:0];
            if (unlock) begin
              nxt_st.modem_control_reg[7:5] = bus_req.wdata[7:5];
            end
          end
        end
        `UIR_OFS_LSTAT: begin
          if (enh) begin
            nxt_st.resume_char_two = bus_req.wdata;
          end else if (!dlab && unlock) begin
            nxt_st.extra_feature_reg = bus_req.wdata;
          end
        end
        `UIR_OFS_MSTAT: begin
          if (enh) begin
            nxt_st.pause_char_one = bus_req.wdata;
          end else if (!dlab && unlock) begin
            nxt_st.infrared_pulse_width_reg = bus_req.wdata;
          end
        end
        `UIR_OFS_SCRATCH: begin
          if (enh) begin
            nxt_st.pause_char_two = bus_req.wdata;
          end else if (!dlab) begin
            nxt_st.spr = bus_req.wdata;
          end
        end
      endcase
    end
    // ----------------------------------------
    // hardware events, applied last so a set beats a clear
    // ----------------------------------------
    if (tx_take && st_ff.thr_full && !(bus_req.wr && !dlab && bus_req.addr == `UIR_OFS_DATA)) begin
      nxt_st.thr_full = 1'b0;
      nxt_st.tx_pend = 1'b1;
    end
    if (!rx_flush) begin
      nxt_st.err_cnt = st_ff.err_cnt + 4'(rx_push && has_err(rx_char))
        - 4'(rd_data_pop && head_vld && has_err(head));
    end
    if (rx_overrun) begin
      nxt_st.ovr = 1'b1;
      nxt_st.ls_pend = 1'b1;
    end
    // error reported on arrival or when it becomes the head byte
    if (st_ff.extra_feature_reg[`UIR_XFR_LSR_MODE_BIT]) begin
      if (rx_push && has_err(rx_char)) begin
        nxt_st.ls_pend = 1'b1;
      end
    end else if (st_ff.hd_fresh && head_vld && has_err(head)) begin
      nxt_st.ls_pend = 1'b1;
    end
    nxt_st.hd_fresh = rd_data_pop || (rx_push && !head_vld);
    // polled mode is simply all four enables clear
    nxt_st.irq = irq_status_reg[0] == 1'b0;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_ff <= '0;
      st_ff.line_control_reg <= `UIR_RST_LCR;
      st_ff.irq_enable_reg <= `UIR_RST_REG;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign bus_rdata = st_ff.rd_data;
  assign irq = st_ff.irq;
  assign tx_vld = st_ff.thr_full;
  assign tx_data = st_ff.tx_holding_reg;

  always_comb begin
    cfg.divisor = {st_ff.divisor_high, st_ff.dll};
    cfg.line_control_reg = st_ff.line_control_reg;
    cfg.modem_control_reg = st_ff.modem_control_reg;
    cfg.enhanced_feature_ctrl = st_ff.enhanced_feature_ctrl;
    cfg.extra_feature_reg = st_ff.extra_feature_reg;
    cfg.infrared_pulse_width_reg = st_ff.infrared_pulse_width_reg;
    cfg.resume_one = st_ff.resume_char_one;
    cfg.resume_two = st_ff.resume_char_two;
    cfg.pause_one = st_ff.pause_char_one;
    cfg.pause_two = st_ff.pause_char_two;
    cfg.fifo_en = st_ff.fifo_en;
    cfg.tx_trig = st_ff.tx_trig;
  end
endmodule : uir_top

`default_nettype wire

// File: sim/uir_monitor.sv
// port checker of the uart register block
// assumes the uir_top ports; bound to it below
`timescale 1ns/100ps
`include "uir_regs.svh"
`default_nettype none
module uir_monitor import uir_pkg::*; (
  input wire logic clk,
  input wire logic srst,
  input wire uir_bus_req_t bus_req,
  input wire logic [7:0] bus_rdata,
  input wire logic irq,
  input wire logic rx_overrun,
  input wire logic tx_vld,
  input wire logic [7:0] tx_data,
  input wire logic tx_take,
  input wire uir_cfg_t cfg
);
  // ------
  // shadow of the low enable bits
  // ------
  // only the four documented sources are tracked, upper bits left out
  logic [3:0] irq_en_ff;
  logic [3:0] nxt_irq_en;
  logic en_wr;
  logic thr_wr;
  assign en_wr = bus_req.wr && bus_req.addr == `UIR_OFS_IEN && !cfg.line_control_reg[7];
  assign thr_wr = bus_req.wr && bus_req.addr == `UIR_OFS_DATA;
  assign nxt_irq_en = en_wr ? bus_req.wdata[3:0] : irq_en_ff;
  always_ff @(posedge clk) begin
    irq_en_ff <= srst ? 4'h0 : nxt_irq_en;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  property p_rdata_idle;
    !bus_req.rd |=> bus_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero without read");
  property p_lcr_wr;
    bus_req.wr && bus_req.addr == `UIR_OFS_LCTL |=> cfg.line_control_reg == $past(bus_req.wdata);
  endproperty
  a_lcr_wr: assert property (p_lcr_wr) else $error("line control not written");
  property p_div_wr;
    thr_wr && cfg.line_control_reg[7] && cfg.line_control_reg != 8'hBF |=> cfg.divisor[7:0] == $past(bus_req.wdata);
  endproperty
  a_div_wr: assert property (p_div_wr) else $error("divisor low not written");
  property p_efr_lock;
    bus_req.wr && bus_req.addr == `UIR_OFS_ISTAT && cfg.line_control_reg != 8'hBF |=> $stable(cfg.enhanced_feature_ctrl);
  endproperty
  a_efr_lock: assert property (p_efr_lock) else $error("locked enhanced register changed");
  property p_efr_wr;
    bus_req.wr && bus_req.addr == `UIR_OFS_ISTAT && cfg.line_control_reg == 8'hBF |=> cfg.enhanced_feature_ctrl == $past(bus_req.wdata);
  endproperty
  a_efr_wr: assert property (p_efr_wr) else $error("enhanced register not written");
  property p_thr_wr;
    thr_wr && !cfg.line_control_reg[7] |=> tx_vld && tx_data == $past(bus_req.wdata);
  endproperty
  a_thr_wr: assert property (p_thr_wr) else $error("holding byte not loaded");
  property p_tx_take;
    tx_vld && tx_take && !thr_wr |=> !tx_vld;
  endproperty
  a_tx_take: assert property (p_tx_take) else $error("holding byte not emptied");
  property p_idle_irq;
    irq_en_ff == 4'h0 [*2] |-> !irq;
  endproperty
  a_idle_irq: assert property (p_idle_irq) else $error("interrupt with all sources masked");
  property p_tx_en_now;
    en_wr && bus_req.wdata[1] && !irq_en_ff[1] && !tx_vld ##1 !bus_req.rd && !bus_req.wr |=> irq;
  endproperty
  a_tx_en_now: assert property (p_tx_en_now) else $error("no interrupt on enabling when empty");
  property p_ovr_irq;
    irq_en_ff[2] && rx_overrun ##1 irq_en_ff[2] && !bus_req.rd |=> irq;
  endproperty
  a_ovr_irq: assert property (p_ovr_irq) else $error("overrun interrupt late");
endmodule : uir_monitor
bind uir_top uir_monitor u_mon (.clk(clk), .srst(srst), .bus_req(bus_req), .bus_rdata(bus_rdata), .irq(irq),
  .rx_overrun(rx_overrun), .tx_vld(tx_vld), .tx_data(tx_data), .tx_take(tx_take), .cfg(cfg));
`default_nettype wire

// File: sim/uir_serial_model.sv
// serial side model: receiver feeding characters, transmitter taking bytes
// assumes the bench fills q, sets dly and calls pulse_overrun
`timescale 1ns/100ps
`default_nettype none
module uir_serial_model import uir_pkg::*; (
  input wire logic clk,
  output uir_rx_char_t rx_char,
  output logic rx_vld,
  input wire logic rx_rdy,
  output logic rx_overrun,
  input wire logic tx_vld,
  output logic tx_take,
  output logic tsr_empty
);
  uir_rx_char_t q[$];
  int dly = 1;
  int wait_cnt = 0;
  int busy_cnt = 0;
  logic took;
  initial begin
    rx_vld = 1'b0;
    rx_char = '0;
    rx_overrun = 1'b0;
    tx_take = 1'b0;
    tsr_empty = 1'b1;
  end
  always @(posedge clk) begin
    took = rx_vld && rx_rdy;
    #1;
    if (took || !rx_vld) begin
      if (q.size() > 0) begin
        rx_char = q.pop_front();
        rx_vld = 1'b1;
      end else begin
        // released: toggle so a stale byte is never mistaken for data
        rx_char = ~rx_char;
        rx_vld = 1'b0;
      end
    end
    wait_cnt = tx_vld ? wait_cnt + 1 : 0;
    // one-cycle take, else a second high cycle would swallow the next byte
    tx_take = tx_vld && !tx_take && wait_cnt > dly;
    busy_cnt = tx_take ? 20 : (busy_cnt > 0 ? busy_cnt - 1 : 0);
    tsr_empty = busy_cnt == 0;
  end
  task automatic pulse_overrun();
    @(posedge clk);
    #1;
    rx_overrun = 1'b1;
    @(posedge clk);
    #1;
    rx_overrun = 1'b0;
  endtask : pulse_overrun
endmodule : uir_serial_model
`default_nettype wire

// File: sim/tb_top.sv
// self-checking bench of the uart register block
// assumes uir_top, the serial side model and the port checker
`timescale 1ns/100ps
`default_nettype none
module tb_top import uir_pkg::*;;
  localparam logic [7:0] REV = 8'h3C; // arbitrary value
  localparam logic [7:0] DEV = 8'h7E; // arbitrary value
  logic clk = 1'b0;
  logic srst = 1'b1;
  uir_bus_req_t bus_req = '0;
  logic [7:0] modem_in = 8'h00;
  logic [7:0] bus_rdata, tx_data;
  logic irq, rx_vld, rx_rdy, rx_overrun, tx_vld, tx_take, tsr_empty;
  uir_rx_char_t rx_char;
  uir_cfg_t cfg;
  int n_errors = 0;
  int n_tests = 0;
  logic [7:0] exp_q[$];
  logic [7:0] sent_q[$];
  logic rd_seen = 1'b0;
  logic [7:0] v[8];
  uir_top #(.REVISION_CODE(REV), .DEVICE_CODE(DEV)) dut (.clk(clk), .srst(srst), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .irq(irq), .rx_vld(rx_vld), .rx_rdy(rx_rdy), .rx_char(rx_char),
    .rx_overrun(rx_overrun), .tx_vld(tx_vld), .tx_data(tx_data), .tx_take(tx_take),
    .tsr_empty(tsr_empty), .modem_in(modem_in), .cfg(cfg));
  uir_serial_model sm (.clk(clk), .rx_char(rx_char), .rx_vld(rx_vld), .rx_rdy(rx_rdy),
    .rx_overrun(rx_overrun), .tx_vld(tx_vld), .tx_take(tx_take), .tsr_empty(tsr_empty));
  initial begin
    forever #5 clk = ~clk;
  end
  // ------
  // tasks
  // ------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    bus_req = '{rd: !w, wr: w, addr: a, wdata: d};
    @(posedge clk);
    #1;
    bus_req = '0;
  endtask : acc
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    acc(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    acc(1'b0, a, 8'h00);
  endtask : rd
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wt
  task automatic send(input int n, input logic [2:0] err);
    uir_rx_char_t c;
    for (int i = 0; i < n; i++) begin
      c = {err, 8'($urandom)};
      sm.q.push_back(c);
      sent_q.push_back(c.data);
    end
  endtask : send
  task automatic fin(input string s);
    $display("test %s done", s);
  endtask : fin
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test
  // read data lands one cycle after the read strobe
  always @(posedge clk) begin
    if (rd_seen) chk(bus_rdata, exp_q.pop_front());
    rd_seen = bus_req.rd;
  end
  initial begin
    #200000;
    n_errors++;
    stop_test();
  end
  // ------
  // tests
  // ------
  initial begin
    void'($urandom(24));
    repeat (16) @(posedge clk);
    #1;
    srst = 1'b0;
    rd(3, 8'h03);
    rd(1, 8'h00);
    rd(2, 8'h01);
    rd(5, 8'h60);
    v[0] = 8'($urandom);
    wr(7, v[0]);
    rd(7, v[0]);
    fin("reset");
    wr(3, 8'h80);
    rd(0, REV);
    rd(1, DEV);
    rd(2, 8'h00);
    v[0] = 8'($urandom);
    v[1] = 8'($urandom) | 8'h01;
    wr(0, v[0]);
    wr(1, v[1]);
    rd(0, v[0]);
    rd(1, v[1]);
    wr(3, 8'hBF);
    v[2] = 8'($urandom) & 8'hEF;
    for (int i = 4; i < 8; i++) begin
      v[i] = 8'($urandom);
    end
    for (int i = 2; i < 8; i++) begin
      if (i != 3) begin
        wr(3'(i), v[i]);
      end
    end
    for (int i = 4; i < 8; i++) rd(3'(i), v[i]);
    rd(2, v[2]);
    rd(0, 8'h00);
    chk(cfg.divisor[15:8], v[1]);
    chk(cfg.resume_one, v[4]);
    chk(cfg.pause_two, v[7]);
    wr(3, 8'h03);
    wr(1, 8'hF0);
    rd(1, 8'h00);
    wr(4, 8'hFF);
    chk(cfg.modem_control_reg, 8'h1F);
    modem_in = 8'hA0;
    rd(6, 8'h00);
    wr(3, 8'hBF);
    wr(2, v[2] | 8'h10);
    wr(3, 8'h03);
    wr(1, 8'hF0);
    rd(1, 8'hF0);
    rd(6, 8'hA0);
    wr(4, 8'hE0);
    chk(cfg.modem_control_reg, 8'hE0);
    wr(1, 8'h00);
    modem_in = 8'h00;
    fin("map");
    wr(2, 8'hB1);
    chk({5'h00, cfg.tx_trig, cfg.fifo_en}, 8'h07);
    wr(1, 8'h01);
    send(3, 3'b000);
    wt(6);
    rd(2, 8'hC1);
    chk({7'h00, irq}, 8'h00);
    rd(5, 8'h61);
    send(1, 3'b000);
    wt(4);
    rd(2, 8'hC4);
    chk({7'h00, irq}, 8'h01);
    rd(0, sent_q.pop_front());
    rd(2, 8'hC1);
    wt(2);
    chk({7'h00, irq}, 8'h00);
    repeat (3) rd(0, sent_q.pop_front());
    rd(5, 8'h60);
    fin("trigger");
    wr(2, 8'h01);
    wr(5, 8'h00);
    wr(1, 8'h05);
    send(1, 3'b000);
    send(1, 3'b001);
    wt(6);
    rd(5, 8'hE1);
    rd(2, 8'hC4);
    rd(0, sent_q.pop_front());
    wt(2);
    rd(2, 8'hC6);
    chk({7'h00, irq}, 8'h01);
    rd(5, 8'hE5);
    rd(2, 8'hC4);
    rd(0, sent_q.pop_front());
    rd(5, 8'h60);
    wr(5, 8'h08);
    chk(cfg.extra_feature_reg, 8'h08);
    send(1, 3'b000);
    send(1, 3'b100);
    wt(6);
    rd(2, 8'hC6);
    rd(5, 8'hE1);
    rd(2, 8'hC4);
    rd(0, sent_q.pop_front());
    rd(5, 8'hF1);
    rd(0, sent_q.pop_front());
    rd(5, 8'h60);
    sm.pulse_overrun();
    wt(3);
    chk({7'h00, irq}, 8'h01);
    rd(5, 8'h62);
    rd(2, 8'hC1);
    fin("errors");
    wr(1, 8'h00);
    send(9, 3'b000);
    wt(14);
    chk({7'h00, rx_rdy}, 8'h00);
    chk({7'h00, irq}, 8'h00);
    rd(5, 8'h61);
    repeat (9) rd(0, sent_q.pop_front());
    rd(5, 8'h60);
    fin("polled");
    sm.dly = 30;
    wr(1, 8'h02);
    wt(2);
    chk({7'h00, irq}, 8'h01);
    rd(2, 8'hC2);
    wt(2);
    chk({7'h00, irq}, 8'h00);
    v[0] = 8'($urandom);
    wr(0, v[0]);
    chk(tx_data, v[0]);
    chk({7'h00, tx_vld}, 8'h01);
    rd(5, 8'h00);
    for (int i = 0; i < 100 && tx_vld === 1'b1; i++) wt(1);
    wt(2);
    chk({7'h00, irq}, 8'h01);
    rd(5, 8'h20);
    wr(0, 8'($urandom));
    wt(2);
    chk({7'h00, irq}, 8'h00);
    wt(60);
    rd(5, 8'h60);
    wr(1, 8'h08);
    modem_in = 8'h01;
    wt(3);
    rd(2, 8'hC0);
    modem_in = 8'h00;
    wr(1, 8'h00);
    fin("transmit");
    send(2, 3'b010);
    wt(6);
    rd(5, 8'hE9);
    wr(2, 8'h03);
    rd(5, 8'h60);
    sent_q.delete();
    wr(2, 8'h00);
    wr(1, 8'h01);
    send(1, 3'b000);
    wt(4);
    chk({7'h00, irq}, 8'h01);
    rd(2, 8'h04);
    rd(0, sent_q.pop_front());
    rd(2, 8'h01);
    wr(1, 8'h00);
    fin("flush");
    wt(4);
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
